// ### design/difei_pkg.sv
// constants for the two-channel filtered input block with edge interrupts
package difei_pkg;
  // clock rate and microsecond divider
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned US_DIV = CLK_MHZ;
  // record set numbers of the parameter records
  localparam logic [7:0] REC_DIAG = 8'h00;
  localparam logic [7:0] REC_DELAY = 8'h01;
  localparam logic [7:0] REC_EDGE = 8'h80;
  // byte positions inside records
  localparam logic [1:0] IDX_CH0 = 2'h0;
  localparam logic [1:0] IDX_CH1 = 2'h1;
  localparam logic [1:0] IDX_RISE = 2'h0;
  localparam logic [1:0] IDX_FALL = 2'h1;
  // diagnostic enable values
  localparam logic [7:0] DIAG_OFF = 8'h00;
  localparam logic [7:0] DIAG_ON = 8'h40;
  // reset values
  localparam logic [7:0] RST_DIAG = 8'h00;
  localparam logic [7:0] RST_DELAY = 8'h02;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_REC = 8'h00;
  // delay codes
  localparam logic [7:0] DLY_CODE_1 = 8'h00;
  localparam logic [7:0] DLY_CODE_3 = 8'h02;
  localparam logic [7:0] DLY_CODE_10 = 8'h04;
  localparam logic [7:0] DLY_CODE_86 = 8'h07;
  localparam logic [7:0] DLY_CODE_342 = 8'h09;
  localparam logic [7:0] DLY_CODE_2731 = 8'h0c;
  // delay times in microseconds
  localparam int unsigned DLY_US_1 = 1;
  localparam int unsigned DLY_US_3 = 3;
  localparam int unsigned DLY_US_10 = 10;
  localparam int unsigned DLY_US_86 = 86;
  localparam int unsigned DLY_US_342 = 342;
  localparam int unsigned DLY_US_2731 = 2731;
  // delay times in clock cycles
  localparam int unsigned DLY_CYC_1 = DLY_US_1 * CLK_MHZ;
  localparam int unsigned DLY_CYC_3 = DLY_US_3 * CLK_MHZ;
  localparam int unsigned DLY_CYC_10 = DLY_US_10 * CLK_MHZ;
  localparam int unsigned DLY_CYC_86 = DLY_US_86 * CLK_MHZ;
  localparam int unsigned DLY_CYC_342 = DLY_US_342 * CLK_MHZ;
  localparam int unsigned DLY_CYC_2731 = DLY_US_2731 * CLK_MHZ;
  localparam int unsigned CNT_W = 17;
  // message kinds for the interrupt record
  localparam logic MSG_DIAG = 1'b0;
  localparam logic MSG_EMCY = 1'b1;
  // record sender states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FLAGS = 5'b00010,
    ST_SNAP = 5'b00100,
    ST_STHI = 5'b01000,
    ST_STLO = 5'b10000
  } difei_state_t;
endpackage

// ### design/difei_top.sv
// two-channel filtered digital input with edge interrupts and records
`timescale 1ns/1ps
module difei_top #(
  parameter int unsigned P_CYC_342 = difei_pkg::DLY_CYC_342,
  parameter int unsigned P_CYC_2731 = difei_pkg::DLY_CYC_2731
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // field inputs
  input wire logic i_input_chan0,
  input wire logic i_input_chan1,
  // parameter record access
  input wire logic i_prm_wr,
  input wire logic i_prm_rd,
  input wire logic [7:0] i_record_set_number,
  input wire logic [1:0] i_prm_idx,
  input wire logic [7:0] i_prm_wdata,
  output logic [7:0] o_prm_rdata,
  // bus mode and diagnostics cause
  input wire logic i_bus_canopen,
  input wire logic i_diag_buf_ovf,
  // process interrupt record stream
  input wire logic i_rec_ready,
  output logic o_rec_valid,
  output logic [7:0] o_rec_byte,
  output logic o_rec_last,
  output logic o_rec_kind,
  // diagnostic interrupt
  output logic o_diag_active,
  output logic o_diag_in,
  output logic o_diag_out,
  // input area
  output logic [7:0] o_input_state
);
  // parameter registers
  logic [7:0] diag_irq_enable_ff, nxt_diag_irq_enable;
  logic [7:0] chan0_filter_delay_ff, nxt_chan0_filter_delay;
  logic [7:0] chan1_filter_delay_ff, nxt_chan1_filter_delay;
  logic [7:0] rising_edge_irq_mask_ff, nxt_rising_edge_irq_mask;
  logic [7:0] falling_edge_irq_mask_ff, nxt_falling_edge_irq_mask;
  logic [7:0] prm_rdata_ff, nxt_prm_rdata;
  logic sel_diag, sel_ch0, sel_ch1, sel_rise, sel_fall;
  // record set and byte decode
  assign sel_diag = (i_record_set_number == difei_pkg::REC_DIAG);
  assign sel_ch0 = (i_record_set_number == difei_pkg::REC_DELAY) && (i_prm_idx == difei_pkg::IDX_CH0);
  assign sel_ch1 = (i_record_set_number == difei_pkg::REC_DELAY) && (i_prm_idx == difei_pkg::IDX_CH1);
  assign sel_rise = (i_record_set_number == difei_pkg::REC_EDGE) && (i_prm_idx == difei_pkg::IDX_RISE);
  assign sel_fall = (i_record_set_number == difei_pkg::REC_EDGE) && (i_prm_idx == difei_pkg::IDX_FALL);
  always_comb begin
    nxt_diag_irq_enable = diag_irq_enable_ff;
    nxt_chan0_filter_delay = chan0_filter_delay_ff;
    nxt_chan1_filter_delay = chan1_filter_delay_ff;
    nxt_rising_edge_irq_mask = rising_edge_irq_mask_ff;
    nxt_falling_edge_irq_mask = falling_edge_irq_mask_ff;
    nxt_prm_rdata = prm_rdata_ff;
    if (i_prm_wr && sel_diag) begin
      nxt_diag_irq_enable = i_prm_wdata;
    end
    if (i_prm_wr && sel_ch0) begin
      nxt_chan0_filter_delay = i_prm_wdata;
    end
    if (i_prm_wr && sel_ch1) begin
      nxt_chan1_filter_delay = i_prm_wdata;
    end
    if (i_prm_wr && sel_rise) begin
      nxt_rising_edge_irq_mask = {6'h00, i_prm_wdata[1:0]};
    end
    if (i_prm_wr && sel_fall) begin
      nxt_falling_edge_irq_mask = {6'h00, i_prm_wdata[1:0]};
    end
    if (i_prm_rd) begin
      nxt_prm_rdata = ({8{sel_diag}} & diag_irq_enable_ff) | ({8{sel_ch0}} & chan0_filter_delay_ff)
        | ({8{sel_ch1}} & chan1_filter_delay_ff) | ({8{sel_rise}} & rising_edge_irq_mask_ff)
        | ({8{sel_fall}} & falling_edge_irq_mask_ff);
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      diag_irq_enable_ff <= difei_pkg::RST_DIAG;
      chan0_filter_delay_ff <= difei_pkg::RST_DELAY;
      chan1_filter_delay_ff <= difei_pkg::RST_DELAY;
      rising_edge_irq_mask_ff <= difei_pkg::RST_EDGE;
      falling_edge_irq_mask_ff <= difei_pkg::RST_EDGE;
      prm_rdata_ff <= 8'h00;
    end else begin
      diag_irq_enable_ff <= nxt_diag_irq_enable;
      chan0_filter_delay_ff <= nxt_chan0_filter_delay;
      chan1_filter_delay_ff <= nxt_chan1_filter_delay;
      rising_edge_irq_mask_ff <= nxt_rising_edge_irq_mask;
      falling_edge_irq_mask_ff <= nxt_falling_edge_irq_mask;
      prm_rdata_ff <= nxt_prm_rdata;
    end
  end
  // delay code to cycle count
  function automatic logic [difei_pkg::CNT_W-1:0] dly_cycles(input logic [7:0] code);
    case (code)
      difei_pkg::DLY_CODE_1: return difei_pkg::CNT_W'(difei_pkg::DLY_CYC_1);
      difei_pkg::DLY_CODE_3: return difei_pkg::CNT_W'(difei_pkg::DLY_CYC_3);
      difei_pkg::DLY_CODE_10: return difei_pkg::CNT_W'(difei_pkg::DLY_CYC_10);
      difei_pkg::DLY_CODE_86: return difei_pkg::CNT_W'(difei_pkg::DLY_CYC_86);
      difei_pkg::DLY_CODE_342: return difei_pkg::CNT_W'(P_CYC_342);
      difei_pkg::DLY_CODE_2731: return difei_pkg::CNT_W'(P_CYC_2731);
      default: return difei_pkg::CNT_W'(difei_pkg::DLY_CYC_3);
    endcase
  endfunction
  // per-channel sync, filter and edge detect
  logic [1:0] raw_in;
  logic [1:0] flt_state;
  logic [1:0] nxt_flt_state;
  logic [1:0] ev_rise;
  logic [1:0] ev_fall;
  logic [difei_pkg::CNT_W-1:0] ch_limit [2];
  assign raw_in = {i_input_chan1, i_input_chan0};
  assign ch_limit[0] = dly_cycles(chan0_filter_delay_ff);
  assign ch_limit[1] = dly_cycles(chan1_filter_delay_ff);
  for (genvar g = 0; g < 2; g++) begin : g_chan
    logic sync1_ff, sync2_ff, flt_ff, nxt_flt;
    logic [difei_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    always_comb begin
      nxt_flt = flt_ff;
      nxt_cnt = '0;
      if (sync2_ff != flt_ff) begin
        if (cnt_ff >= ch_limit[g] - difei_pkg::CNT_W'(1)) begin
          nxt_flt = sync2_ff;
        end else begin
          nxt_cnt = cnt_ff + difei_pkg::CNT_W'(1);
        end
      end
    end
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        sync1_ff <= 1'b0;
        sync2_ff <= 1'b0;
        flt_ff <= 1'b0;
        cnt_ff <= '0;
      end else begin
        sync1_ff <= raw_in[g];
        sync2_ff <= sync1_ff;
        flt_ff <= nxt_flt;
        cnt_ff <= nxt_cnt;
      end
    end
    assign flt_state[g] = flt_ff;
    assign nxt_flt_state[g] = nxt_flt;
    assign ev_rise[g] = nxt_flt & ~flt_ff;
    assign ev_fall[g] = ~nxt_flt & flt_ff;
  end
  // microsecond ticker
  logic [4:0] us_div_ff, nxt_us_div;
  logic [31:0] us_tick_ff, nxt_us_tick;
  always_comb begin
    nxt_us_div = us_div_ff + 5'h01;
    nxt_us_tick = us_tick_ff;
    if (us_div_ff == 5'(difei_pkg::US_DIV - 1)) begin
      nxt_us_div = 5'h00;
      nxt_us_tick = us_tick_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      us_div_ff <= 5'h00;
      us_tick_ff <= 32'h0000_0000;
    end else begin
      us_div_ff <= nxt_us_div;
      us_tick_ff <= nxt_us_tick;
    end
  end
  // process interrupt record sender
  difei_pkg::difei_state_t state_ff, nxt_state;
  logic [7:0] edge_source_flags_ff, nxt_edge_source_flags;
  logic [7:0] input_state_snapshot_ff, nxt_input_state_snapshot;
  logic [15:0] microsecond_stamp_ff, nxt_microsecond_stamp;
  logic rec_valid_ff, nxt_rec_valid;
  logic [7:0] rec_byte_ff, nxt_rec_byte;
  logic rec_last_ff, nxt_rec_last;
  logic rec_kind_ff, nxt_rec_kind;
  logic lost_ff, nxt_lost;
  logic [1:0] hit;
  assign hit = (ev_rise & rising_edge_irq_mask_ff[1:0]) | (ev_fall & falling_edge_irq_mask_ff[1:0]);

  always_comb begin
    nxt_state = state_ff;
    nxt_edge_source_flags = edge_source_flags_ff;
    nxt_input_state_snapshot = input_state_snapshot_ff;
    nxt_microsecond_stamp = microsecond_stamp_ff;
    nxt_rec_valid = rec_valid_ff;
    nxt_rec_byte = rec_byte_ff;
    nxt_rec_last = rec_last_ff;
    nxt_rec_kind = rec_kind_ff;
    nxt_lost = lost_ff;
    case (state_ff)
      difei_pkg::ST_IDLE: begin
        if (hit != 2'b00) begin
          nxt_edge_source_flags = {6'h00, hit};
          nxt_input_state_snapshot = {6'h00, nxt_flt_state};
          nxt_microsecond_stamp = us_tick_ff[15:0];
          nxt_rec_kind = i_bus_canopen ? difei_pkg::MSG_EMCY : difei_pkg::MSG_DIAG;
          nxt_rec_valid = 1'b1;
          nxt_rec_byte = {6'h00, hit};
          nxt_rec_last = 1'b0;
          nxt_state = difei_pkg::ST_FLAGS;
        end
      end
      difei_pkg::ST_FLAGS: begin
        if (i_rec_ready) begin
          nxt_rec_byte = input_state_snapshot_ff;
          nxt_state = difei_pkg::ST_SNAP;
        end
      end
      difei_pkg::ST_SNAP: begin
        if (i_rec_ready) begin
          nxt_rec_byte = microsecond_stamp_ff[15:8];
          nxt_state = difei_pkg::ST_STHI;
        end
      end
      difei_pkg::ST_STHI: begin
        if (i_rec_ready) begin
          nxt_rec_byte = microsecond_stamp_ff[7:0];
          nxt_rec_last = 1'b1;
          nxt_state = difei_pkg::ST_STLO;
        end
      end
      difei_pkg::ST_STLO: begin
        if (i_rec_ready) begin
          nxt_rec_valid = 1'b0;
          nxt_rec_last = 1'b0;
          nxt_rec_byte = difei_pkg::RST_REC;
          nxt_lost = 1'b0;
          nxt_state = difei_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = difei_pkg::ST_IDLE;
        nxt_rec_valid = 1'b0;
      end
    endcase
    // edge while busy is lost, set wins
    if (state_ff != difei_pkg::ST_IDLE && hit != 2'b00) begin
      nxt_lost = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_ff <= difei_pkg::ST_IDLE;
      edge_source_flags_ff <= difei_pkg::RST_REC;
      input_state_snapshot_ff <= difei_pkg::RST_REC;
      microsecond_stamp_ff <= 16'h0000;
      rec_valid_ff <= 1'b0;
      rec_byte_ff <= difei_pkg::RST_REC;
      rec_last_ff <= 1'b0;
      rec_kind_ff <= difei_pkg::MSG_DIAG;
      lost_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      edge_source_flags_ff <= nxt_edge_source_flags;
      input_state_snapshot_ff <= nxt_input_state_snapshot;
      microsecond_stamp_ff <= nxt_microsecond_stamp;
      rec_valid_ff <= nxt_rec_valid;
      rec_byte_ff <= nxt_rec_byte;
      rec_last_ff <= nxt_rec_last;
      rec_kind_ff <= nxt_rec_kind;
      lost_ff <= nxt_lost;
    end
  end
  // diagnostic interrupt
  logic diag_active_ff, nxt_diag_active;
  logic diag_in_ff, nxt_diag_in;
  logic diag_out_ff, nxt_diag_out;
  logic [7:0] input_state_ff, nxt_input_state;
  logic diag_cause;
  assign diag_cause = (diag_irq_enable_ff == difei_pkg::DIAG_ON) & (i_diag_buf_ovf | lost_ff);

  always_comb begin
    nxt_diag_active = diag_cause;
    nxt_diag_in = diag_cause & ~diag_active_ff;
    nxt_diag_out = ~diag_cause & diag_active_ff;
    nxt_input_state = {6'h00, flt_state};
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      diag_active_ff <= 1'b0;
      diag_in_ff <= 1'b0;
      diag_out_ff <= 1'b0;
      input_state_ff <= 8'h00;
    end else begin
      diag_active_ff <= nxt_diag_active;
      diag_in_ff <= nxt_diag_in;
      diag_out_ff <= nxt_diag_out;
      input_state_ff <= nxt_input_state;
    end
  end

  assign o_prm_rdata = prm_rdata_ff;
  assign o_rec_valid = rec_valid_ff;
  assign o_rec_byte = rec_byte_ff;
  assign o_rec_last = rec_last_ff;
  assign o_rec_kind = rec_kind_ff;
  assign o_diag_active = diag_active_ff;
  assign o_diag_in = diag_in_ff;
  assign o_diag_out = diag_out_ff;
  assign o_input_state = input_state_ff;

endmodule

// ### verif/difei_monitor.sv
// assertion checker for the filtered input block
`timescale 1ns/1ps
module difei_monitor (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // watched inputs
  input wire logic i_rec_ready,
  input wire logic i_bus_canopen,
  // watched outputs
  input wire logic o_rec_valid,
  input wire logic [7:0] o_rec_byte,
  input wire logic o_rec_last,
  input wire logic o_rec_kind,
  input wire logic o_diag_active,
  input wire logic o_diag_in,
  input wire logic o_diag_out,
  input wire logic [7:0] o_input_state
);
  logic [1:0] beat_ff;
  logic [1:0] nxt_beat;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // accepted bytes of current record
  always_comb begin
    nxt_beat = beat_ff;
    if (o_rec_valid && i_rec_ready) begin
      nxt_beat = o_rec_last ? 2'h0 : beat_ff + 2'h1;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      beat_ff <= 2'h0;
    end else begin
      beat_ff <= nxt_beat;
    end
  end
  AST_DIAG_IN: assert property (o_diag_in |-> o_diag_active && !$past(o_diag_active))
    else $error("diag in pulse without rise");
  AST_DIAG_OUT: assert property (o_diag_out |-> !o_diag_active && $past(o_diag_active))
    else $error("diag out pulse without fall");
  AST_DIAG_FALL: assert property ($fell(o_diag_active) |-> o_diag_out)
    else $error("diag fall without out pulse");
  AST_DIAG_RISE: assert property ($rose(o_diag_active) |-> o_diag_in)
    else $error("diag rise without in pulse");
  AST_REC_HOLD: assert property (o_rec_valid && !i_rec_ready |=> o_rec_valid && $stable(o_rec_byte))
    else $error("record byte not held");
  AST_REC_LEN: assert property (o_rec_valid && o_rec_last |-> beat_ff == 2'h3)
    else $error("last byte not fourth");
  AST_FLAGS: assert property ($rose(o_rec_valid) |-> o_rec_byte[7:2] == 6'h00 && o_rec_byte[1:0] != 2'h0)
    else $error("bad edge flags byte");
  AST_KIND: assert property ($rose(o_rec_valid) && $stable(i_bus_canopen) |-> o_rec_kind == i_bus_canopen)
    else $error("record kind wrong");
  AST_FILT: assert property ($changed(o_input_state[0]) |=> $stable(o_input_state[0]) [*8])
    else $error("filtered input changed too fast");
endmodule
bind difei_top difei_monitor u_mon (.i_core_clk, .i_rst_n, .i_rec_ready, .i_bus_canopen, .o_rec_valid,
  .o_rec_byte, .o_rec_last, .o_rec_kind, .o_diag_active, .o_diag_in, .o_diag_out, .o_input_state);

// ### verif/difei_sink.sv
// record sink model standing in for the controller
`timescale 1ns/1ps
module difei_sink (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // stall controls
  input wire logic i_slow,
  input wire logic i_hold,
  // record stream
  input wire logic i_rec_valid,
  input wire logic [7:0] i_rec_byte,
  input wire logic i_rec_last,
  input wire logic i_rec_kind,
  output logic o_rec_ready,
  // captured record
  output logic [31:0] o_rec,
  output logic o_kind,
  output logic [7:0] o_count
);
  logic [23:0] acc;
  initial begin
    o_rec_ready = 1'b0;
  end
  // ready moves after the edge
  always @(negedge i_core_clk) begin
    o_rec_ready <= !i_hold && (!i_slow || !o_rec_ready);
  end
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      acc <= 24'h0;
      o_rec <= 32'h0;
      o_kind <= 1'b0;
      o_count <= 8'h00;
    end else if (i_rec_valid && o_rec_ready) begin
      acc <= {acc[15:0], i_rec_byte};
      o_kind <= i_rec_kind;
      if (i_rec_last) begin
        o_rec <= {acc, i_rec_byte};
        o_count <= o_count + 8'h01;
      end
    end
  end
endmodule

// ### verif/difei_top_tb.sv
// self-checking bench for the filtered input block
`timescale 1ns/1ps
module difei_top_tb;
  logic clk, rst_n, ch0, ch1, wr, rd, canopen, ovf, ready, valid, last, kind, dact, slow, hold, skind;
  logic [7:0] set, wdata, rdata, rbyte, state, cnt;
  logic [1:0] idx;
  logic [31:0] rec;
  int failures, cmp_count, seed, cyc, g;
  logic [7:0] codes [6] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c};
  int cycs [6] = '{25, 75, 250, 2150, 40, 80};
  difei_top #(.P_CYC_342(40), .P_CYC_2731(80)) u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_input_chan0(ch0),
    .i_input_chan1(ch1), .i_prm_wr(wr), .i_prm_rd(rd), .i_record_set_number(set), .i_prm_idx(idx),
    .i_prm_wdata(wdata), .o_prm_rdata(rdata), .i_bus_canopen(canopen), .i_diag_buf_ovf(ovf), .i_rec_ready(ready),
    .o_rec_valid(valid), .o_rec_byte(rbyte), .o_rec_last(last), .o_rec_kind(kind), .o_diag_active(dact),
    .o_diag_in(), .o_diag_out(), .o_input_state(state));
  difei_sink u_sink (.i_core_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_hold(hold), .i_rec_valid(valid),
    .i_rec_byte(rbyte), .i_rec_last(last), .i_rec_kind(kind), .o_rec_ready(ready), .o_rec(rec), .o_kind(skind),
    .o_count(cnt));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;
  function automatic logic [31:0] bit_at(input bit c, input bit v);
    return v ? (c ? 32'h2 : 32'h1) : 32'h0;
  endfunction
  task automatic finish_test();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp_near(input string name, input int exp, input logic [15:0] got);
    logic [15:0] d;
    d = got - exp[15:0];
    cmp_count++;
    if ((d inside {16'h0, 16'h1, 16'h2, 16'hffff, 16'hfffe}) !== 1'b1) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp[15:0], got);
    end
  endtask
  task automatic wr_prm(input logic [7:0] s, input logic [1:0] i, input logic [7:0] d);
    set = s;
    idx = i;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] s, input logic [1:0] i, input logic [7:0] exp);
    set = s;
    idx = i;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    cmp("prm_rdata", {24'h0, exp}, {24'h0, rdata});
  endtask
  task automatic edge_chk(input bit c, input bit lvl, input int n);
    logic [7:0] c0;
    int t0;
    c0 = cnt;
    t0 = cyc;
    ch0 = c ? ch0 : lvl;
    ch1 = c ? lvl : ch1;
    repeat (n) @(negedge clk);
    cmp("input_state", bit_at(c, !lvl), {24'h0, state});
    for (int k = 0; k < 60 && cnt === c0; k++) begin
      @(negedge clk);
    end
    if (cnt === c0) begin
      failures++;
      $display("ERROR record_count expected %h seen %h", c0 + 8'h01, cnt);
      finish_test();
    end
    cmp("input_state", bit_at(c, lvl), {24'h0, state});
    cmp("edge_flags", bit_at(c, 1'b1), {24'h0, rec[31:24]});
    cmp("snapshot", bit_at(c, lvl), {24'h0, rec[23:16]});
    cmp("rec_kind", {31'h0, canopen}, {31'h0, skind});
    cmp("diag_active", 32'h0, {31'h0, dact});
    cmp_near("stamp", (t0 + n + 2) / 25, rec[15:0]);
  endtask
  initial begin
    seed = 32'hbe103b7a;
    {failures, cmp_count, cyc} = '0;
    {rst_n, ch0, ch1, wr, rd, set, idx, wdata, canopen, ovf, slow, hold} = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(8'h00, 2'h0, 8'h00);
    rd_chk(8'h01, 2'h0, 8'h02);
    rd_chk(8'h01, 2'h1, 8'h02);
    rd_chk(8'h80, 2'h0, 8'h00);
    rd_chk(8'h80, 2'h1, 8'h00);
    rd_chk(8'h55, 2'h0, 8'h00);
    ch0 = 1'b1;
    repeat (90) @(negedge clk);
    ch0 = 1'b0;
    repeat (90) @(negedge clk);
    cmp("rec_count", 32'h0, {24'h0, cnt});
    wr_prm(8'h80, 2'h0, 8'hff);
    wr_prm(8'h80, 2'h1, 8'hfd);
    rd_chk(8'h80, 2'h0, 8'h03);
    rd_chk(8'h80, 2'h1, 8'h01);
    wr_prm(8'h00, 2'h0, 8'h40);
    for (int k = 0; k < 6; k++) begin
      wr_prm(8'h01, 2'h0, codes[k]);
      wr_prm(8'h01, 2'h1, codes[k]);
      canopen = 1'($random(seed));
      slow = 1'($random(seed));
      g = ($random(seed) & 32'hffff) % (cycs[k] - 4) + 1;
      ch1 = 1'b1;
      repeat (g) @(negedge clk);
      ch1 = 1'b0;
      repeat (cycs[k] + 8) @(negedge clk);
      cmp("input_state", 32'h0, {24'h0, state});
      edge_chk(1'b0, 1'b1, cycs[k]);
      edge_chk(1'b0, 1'b0, cycs[k]);
    end
    edge_chk(1'b1, 1'b1, 80);
    ch1 = 1'b0;
    repeat (100) @(negedge clk);
    cmp("rec_count", 32'hd, {24'h0, cnt});
    hold = 1'b1;
    ch0 = 1'b1;
    repeat (100) @(negedge clk);
    ch0 = 1'b0;
    repeat (100) @(negedge clk);
    cmp("diag_active", 32'h1, {31'h0, dact});
    hold = 1'b0;
    repeat (20) @(negedge clk);
    cmp("diag_active", 32'h0, {31'h0, dact});
    cmp("rec_count", 32'he, {24'h0, cnt});
    ovf = 1'b1;
    repeat (5) @(negedge clk);
    cmp("diag_active", 32'h1, {31'h0, dact});
    ovf = 1'b0;
    repeat (3) @(negedge clk);
    cmp("diag_active", 32'h0, {31'h0, dact});
    wr_prm(8'h00, 2'h0, 8'h41);
    ovf = 1'b1;
    repeat (5) @(negedge clk);
    cmp("diag_active", 32'h0, {31'h0, dact});
    ovf = 1'b0;
    finish_test();
  end
endmodule
